// >>> pkg/drive_status_params.svh
`ifndef DRIVE_STATUS_PARAMS_SVH
`define DRIVE_STATUS_PARAMS_SVH

// Clock and time base
`define CLK_PERIOD_NS       10
`define TICK_PERIOD_NS      1000000
`define REGEN_HOLD_MS       100
`define STALL_TIME_MS       3000

// Widths
`define FREQ_W              16
`define SPEED_W             17
`define CODE_W              8
`define NUM_TERMINALS       7
`define ADDR_W              8
`define DATA_W              16

// Register byte offsets
`define REG_REACH_BAND      8'h00
`define REG_THRESH1         8'h04
`define REG_REV_THRESH      8'h08
`define REG_THRESH2         8'h0C
`define REG_THRESH3         8'h10
`define REG_LOW_SPEED       8'h14
`define REG_STALL_TORQUE    8'h18
`define REG_STATUS          8'h1C
`define REG_TERM_BASE       8'h20
`define REG_TERM_STEP       8'h04

// Reset values, frequencies in 0.01 Hz, percentages in 1 %
`define RST_REACH_BAND      16'h000A
`define RST_THRESH1         16'h0258
`define RST_REV_THRESH      16'h270F
`define RST_THRESH2         16'h0BB8
`define RST_THRESH3         16'h1770
`define RST_LOW_SPEED       16'h0096
`define RST_STALL_TORQUE    16'h0096
`define RST_TERM_CODE       8'h00
`define REV_THRESH_SAME     16'h270F
`define PERCENT_FULL        8'h64

// Terminal function codes
`define FN_INVERT_OFFSET    8'h64
`define FN_CMD_THRESH1      8'h04
`define FN_CMD_THRESH2      8'h05
`define FN_CMD_THRESH3      8'h06
`define FN_FWD_DIR          8'h1E
`define FN_REV_DIR          8'h1F
`define FN_REGEN            8'h20
`define FN_LOW_SPEED        8'h22
`define FN_FBK_THRESH1      8'h29
`define FN_FBK_THRESH2      8'h2A
`define FN_FBK_THRESH3      8'h2B
`define FN_SHUTOFF          8'h5B
`define FN_FAULT_SECONDARY  8'h5E

// Fault codes that open the supply contactor
`define FC_INRUSH           8'h01
`define FC_CPU              8'h02
`define FC_CPU_5            8'h03
`define FC_CPU_6            8'h04
`define FC_CPU_7            8'h05
`define FC_PARAM_STORE      8'h06
`define FC_PARAM_STORE2     8'h07
`define FC_AUX_SHORT        8'h08
`define FC_PANEL_SHORT      8'h09
`define FC_GROUND_FAULT     8'h0A
`define FC_PHASE_LOSS       8'h0B
`define FC_BRAKE_TR         8'h0C

`endif

// >>> pkg/drive_status_pkg.sv
`include "drive_status_params.svh"

package drive_status_pkg;

  typedef enum logic [2:0] {
    CM_VF     = 3'h0,
    CM_AMFV   = 3'h1,
    CM_SLV    = 3'h2,
    CM_VECTOR = 3'h3,
    CM_ENC_FB = 3'h4
  } ctrl_method_t;

  typedef enum logic [1:0] {
    MODE_SPEED    = 2'h0,
    MODE_TORQUE   = 2'h1,
    MODE_POSITION = 2'h2
  } ctrl_mode_t;

  typedef enum logic [1:0] {
    STALL_IDLE    = 2'b00,
    STALL_WATCH   = 2'b01,
    STALL_TRIPPED = 2'b11
  } stall_state_t;

  typedef struct packed {
    ctrl_method_t                method;
    ctrl_mode_t                  mode;
    logic                        running;
    logic                        pre_excitation;
    logic                        dc_brake;
    logic                        start_tuning;
    logic                        regenerating;
    logic                        torque_limit_active;
    logic                        trip;
    logic                        reset_period;
    logic                        fault_reset;
    logic [`CODE_W-1:0]          fault_code;
    logic signed [`SPEED_W-1:0]  output_freq;
    logic signed [`SPEED_W-1:0]  freq_command;
    logic signed [`SPEED_W-1:0]  motor_speed;
    logic [`FREQ_W-1:0]          set_freq;
    logic [`FREQ_W-1:0]          torque;
  } drive_in_t;

  typedef struct packed {
    logic stall_trip_fault;
    logic low_speed_flag;
    logic fbk_thresh3_flag;
    logic cmd_thresh3_flag;
    logic fbk_thresh2_flag;
    logic cmd_thresh2_flag;
    logic fbk_thresh1_flag;
    logic cmd_thresh1_flag;
    logic freq_reached_flag;
    logic supply_contactor_shutoff;
    logic fault_out_secondary;
    logic fault_out_primary;
    logic regen_state_flag;
    logic rev_dir_flag;
    logic fwd_dir_flag;
  } flags_t;

  typedef struct packed {
    logic [`FREQ_W-1:0] reach_band_setting;
    logic [`FREQ_W-1:0] thresh1_setting;
    logic [`FREQ_W-1:0] reverse_thresh_setting;
    logic [`FREQ_W-1:0] thresh2_setting;
    logic [`FREQ_W-1:0] thresh3_setting;
    logic [`FREQ_W-1:0] low_speed_setting;
    logic [`FREQ_W-1:0] stall_torque_level;
  } settings_t;

endpackage

// >>> rtl/drive_status_signal_generator.sv
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
`include "drive_status_params.svh"

module drive_status_signal_generator
  import drive_status_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire drive_in_t                 drive_in,
  input  wire logic [`ADDR_W-1:0]        reg_addr,
  input  wire logic [`DATA_W-1:0]        reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [`DATA_W-1:0]        reg_rdata,
  output logic      [`NUM_TERMINALS-1:0] terminal_out,
  output flags_t                         flags
);

  localparam int unsigned REGEN_HOLD_TICKS =
    (`REGEN_HOLD_MS * 1000000 + `TICK_PERIOD_NS - 1) / `TICK_PERIOD_NS;
  // Divide first: the plain product of ms and ns overflows 32 bits
  localparam int unsigned STALL_TICKS =
    `STALL_TIME_MS / (`TICK_PERIOD_NS / 1000000);

  typedef struct packed {
    settings_t                               set;
    logic [`NUM_TERMINALS-1:0][`CODE_W-1:0]  codes;
    logic [16:0]                             tick_cnt;
    logic                                    tick;
    logic [6:0]                              regen_hold;
    logic [11:0]                             stall_cnt;
    stall_state_t                            stall_state;
    flags_t                                  flags;
    logic [`NUM_TERMINALS-1:0]               terminals;
    logic [`DATA_W-1:0]                      rdata;
  } state_t;

  state_t state;
  state_t next_state;

  function automatic logic [`FREQ_W-1:0] magnitude(
    input logic signed [`SPEED_W-1:0] v
  );
    logic [`SPEED_W-1:0] m;
    m = v[`SPEED_W-1] ? `SPEED_W'(-v) : `SPEED_W'(v);
    return m[`SPEED_W-1] ? {`FREQ_W{1'b1}} : m[`FREQ_W-1:0];
  endfunction

  function automatic logic contactor_fault(input logic [`CODE_W-1:0] code);
    case (code)
      `FC_INRUSH, `FC_CPU, `FC_CPU_5, `FC_CPU_6, `FC_CPU_7,
      `FC_PARAM_STORE, `FC_PARAM_STORE2, `FC_AUX_SHORT, `FC_PANEL_SHORT,
      `FC_GROUND_FAULT, `FC_PHASE_LOSS, `FC_BRAKE_TR: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Unknown codes leave the terminal low in either polarity
  function automatic logic route(
    input logic [`CODE_W-1:0] code,
    input flags_t             f
  );
    logic [`CODE_W-1:0] base;
    logic               inv;
    logic               val;
    logic               known;
    inv   = code >= `FN_INVERT_OFFSET;
    base  = inv ? code - `FN_INVERT_OFFSET : code;
    known = 1'b1;
    val   = 1'b0;
    case (base)
      `FN_CMD_THRESH1:     val = f.cmd_thresh1_flag;
      `FN_CMD_THRESH2:     val = f.cmd_thresh2_flag;
      `FN_CMD_THRESH3:     val = f.cmd_thresh3_flag;
      `FN_FBK_THRESH1:     val = f.fbk_thresh1_flag;
      `FN_FBK_THRESH2:     val = f.fbk_thresh2_flag;
      `FN_FBK_THRESH3:     val = f.fbk_thresh3_flag;
      `FN_FWD_DIR:         val = f.fwd_dir_flag;
      `FN_REV_DIR:         val = f.rev_dir_flag;
      `FN_REGEN:           val = f.regen_state_flag;
      `FN_LOW_SPEED:       val = f.low_speed_flag;
      `FN_SHUTOFF:         val = f.supply_contactor_shutoff;
      `FN_FAULT_SECONDARY: val = f.fault_out_secondary;
      default:             known = 1'b0;
    endcase
    return known & (val ^ inv);
  endfunction

  // Frequency compare signals
  logic                        vector_method;
  logic                        freq_block;
  logic signed [`SPEED_W-1:0]  cmd_freq;
  logic signed [`SPEED_W-1:0]  fbk_freq;
  logic [`FREQ_W-1:0]          cmd_mag;
  logic [`FREQ_W-1:0]          fbk_mag;
  logic [`FREQ_W-1:0]          cmd_thr1;
  logic [`FREQ_W-1:0]          fbk_thr1;
  logic [`FREQ_W:0]            reach_diff;
  logic [31:0]                 reach_lhs;
  logic [31:0]                 reach_rhs;
  logic                        dir_gate;
  logic                        regen_gate;
  logic                        stall_cond;
  flags_t                      f;

  always_comb begin
    vector_method = drive_in.method == CM_VECTOR;
    unique case (drive_in.method)
      CM_VF, CM_AMFV: begin
        cmd_freq = drive_in.output_freq;
        fbk_freq = drive_in.output_freq;
      end
      CM_ENC_FB: begin
        cmd_freq = drive_in.motor_speed;
        fbk_freq = drive_in.motor_speed;
      end
      default: begin
        cmd_freq = drive_in.freq_command;
        fbk_freq = drive_in.motor_speed;
      end
    endcase
    cmd_mag = magnitude(cmd_freq);
    fbk_mag = magnitude(fbk_freq);

    freq_block = drive_in.dc_brake | drive_in.pre_excitation |
                 drive_in.start_tuning;

    cmd_thr1 = (state.set.reverse_thresh_setting == `REV_THRESH_SAME ||
                !cmd_freq[`SPEED_W-1]) ? state.set.thresh1_setting
                                       : state.set.reverse_thresh_setting;
    fbk_thr1 = (state.set.reverse_thresh_setting == `REV_THRESH_SAME ||
                !fbk_freq[`SPEED_W-1]) ? state.set.thresh1_setting
                                       : state.set.reverse_thresh_setting;

    reach_diff = (fbk_mag >= drive_in.set_freq) ?
                 (`FREQ_W+1)'(fbk_mag - drive_in.set_freq) :
                 (`FREQ_W+1)'(drive_in.set_freq - fbk_mag);
    reach_lhs = 32'(reach_diff) * 32'(`PERCENT_FULL);
    reach_rhs = 32'(drive_in.set_freq) *
                32'(state.set.reach_band_setting);

    dir_gate = vector_method & drive_in.running &
               (!drive_in.pre_excitation ||
                drive_in.mode == MODE_POSITION);
    regen_gate = vector_method & drive_in.running &
                 !drive_in.pre_excitation;

    f = '0;
    f.fwd_dir_flag = dir_gate & !drive_in.motor_speed[`SPEED_W-1] &
                     (drive_in.motor_speed != '0);
    f.rev_dir_flag = dir_gate & drive_in.motor_speed[`SPEED_W-1];

    f.regen_state_flag = regen_gate &
                         (drive_in.regenerating | (state.regen_hold != '0));

    f.fault_out_primary   = drive_in.trip;
    f.fault_out_secondary = drive_in.trip |
                            (state.flags.fault_out_secondary &
                             drive_in.reset_period);
    f.supply_contactor_shutoff = drive_in.trip &
                                 contactor_fault(drive_in.fault_code);

    f.freq_reached_flag = !freq_block & (reach_lhs <= reach_rhs);
    f.cmd_thresh1_flag = !freq_block & (cmd_mag >= cmd_thr1);
    f.fbk_thresh1_flag = !freq_block & (fbk_mag >= fbk_thr1);
    f.cmd_thresh2_flag = !freq_block &
                         (cmd_mag >= state.set.thresh2_setting);
    f.fbk_thresh2_flag = !freq_block &
                         (fbk_mag >= state.set.thresh2_setting);
    f.cmd_thresh3_flag = !freq_block &
                         (cmd_mag >= state.set.thresh3_setting);
    f.fbk_thresh3_flag = !freq_block &
                         (fbk_mag >= state.set.thresh3_setting);
    f.low_speed_flag = !freq_block &
                       (fbk_mag < state.set.low_speed_setting);

    stall_cond = (drive_in.method == CM_SLV || vector_method) &
                 drive_in.mode == MODE_SPEED & drive_in.running &
                 drive_in.torque_limit_active &
                 (fbk_mag <= state.set.low_speed_setting) &
                 (drive_in.torque > state.set.stall_torque_level);
    f.stall_trip_fault = state.stall_state == STALL_TRIPPED;
  end

  always_comb begin
    next_state = state;

    next_state.tick = 1'b0;
    if (state.tick_cnt == 17'(TICK_CYCLES - 1)) begin
      next_state.tick_cnt = '0;
      next_state.tick     = 1'b1;
    end else begin
      next_state.tick_cnt = state.tick_cnt + 17'h0_0001;
    end

    if (drive_in.regenerating && regen_gate) begin
      next_state.regen_hold = 7'(REGEN_HOLD_TICKS);
    end else if (!regen_gate) begin
      next_state.regen_hold = '0;
    end else if (state.tick && state.regen_hold != '0) begin
      next_state.regen_hold = state.regen_hold - 7'h01;
    end

    unique case (state.stall_state)
      STALL_IDLE: begin
        next_state.stall_cnt = '0;
        if (stall_cond) begin
          next_state.stall_state = STALL_WATCH;
        end
      end
      STALL_WATCH: begin
        if (!stall_cond) begin
          next_state.stall_state = STALL_IDLE;
        end else if (state.stall_cnt > 12'(STALL_TICKS)) begin
          next_state.stall_state = STALL_TRIPPED;
        end else if (state.tick) begin
          next_state.stall_cnt = state.stall_cnt + 12'h001;
        end
      end
      STALL_TRIPPED: begin
        if (drive_in.fault_reset) begin
          next_state.stall_state = STALL_IDLE;
        end
      end
      default: next_state.stall_state = STALL_IDLE;
    endcase

    next_state.flags = f;
    for (int i = 0; i < `NUM_TERMINALS; i++) begin
      next_state.terminals[i] = route(state.codes[i], f);
    end

    if (reg_wr) begin
      unique case (reg_addr)
        `REG_REACH_BAND:   next_state.set.reach_band_setting     = reg_wdata;
        `REG_THRESH1:      next_state.set.thresh1_setting        = reg_wdata;
        `REG_REV_THRESH:   next_state.set.reverse_thresh_setting = reg_wdata;
        `REG_THRESH2:      next_state.set.thresh2_setting        = reg_wdata;
        `REG_THRESH3:      next_state.set.thresh3_setting        = reg_wdata;
        `REG_LOW_SPEED:    next_state.set.low_speed_setting      = reg_wdata;
        `REG_STALL_TORQUE: next_state.set.stall_torque_level     = reg_wdata;
        default: begin
          for (int i = 0; i < `NUM_TERMINALS; i++) begin
            if (reg_addr == `ADDR_W'(`REG_TERM_BASE + i * `REG_TERM_STEP))
              next_state.codes[i] = reg_wdata[`CODE_W-1:0];
          end
        end
      endcase
    end

    // Read data stands for one cycle only, zero otherwise
    next_state.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `REG_REACH_BAND:   next_state.rdata = state.set.reach_band_setting;
        `REG_THRESH1:      next_state.rdata = state.set.thresh1_setting;
        `REG_REV_THRESH:   next_state.rdata = state.set.reverse_thresh_setting;
        `REG_THRESH2:      next_state.rdata = state.set.thresh2_setting;
        `REG_THRESH3:      next_state.rdata = state.set.thresh3_setting;
        `REG_LOW_SPEED:    next_state.rdata = state.set.low_speed_setting;
        `REG_STALL_TORQUE: next_state.rdata = state.set.stall_torque_level;
        `REG_STATUS:       next_state.rdata = `DATA_W'(state.flags);
        default: begin
          for (int i = 0; i < `NUM_TERMINALS; i++) begin
            if (reg_addr == `ADDR_W'(`REG_TERM_BASE + i * `REG_TERM_STEP))
              next_state.rdata = `DATA_W'(state.codes[i]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state                            <= '0;
      state.set.reach_band_setting     <= `RST_REACH_BAND;
      state.set.thresh1_setting        <= `RST_THRESH1;
      state.set.reverse_thresh_setting <= `RST_REV_THRESH;
      state.set.thresh2_setting        <= `RST_THRESH2;
      state.set.thresh3_setting        <= `RST_THRESH3;
      state.set.low_speed_setting      <= `RST_LOW_SPEED;
      state.set.stall_torque_level     <= `RST_STALL_TORQUE;
      state.stall_state                <= STALL_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata    = state.rdata;
  assign terminal_out = state.terminals;
  assign flags        = state.flags;

endmodule // drive_status_signal_generator

// >>> dv/terminal_reader.sv
`timescale 1ns/10ps
`include "drive_status_params.svh"
// Controller side: scans the terminals once a clock like an input card,
// so every reading it reports lags the pins by one cycle
module terminal_reader (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic [`NUM_TERMINALS-1:0] terminal_out,
  output logic      [`NUM_TERMINALS-1:0] seen
);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      seen <= '0;
    end else begin
      seen <= terminal_out;
    end
  end
endmodule // terminal_reader

// >>> dv/drive_status_checker.sv
`timescale 1ns/10ps
`include "drive_status_params.svh"
module drive_status_checker
  import drive_status_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 10
) (
  input wire logic                      clk_sys,
  input wire logic                      rst,
  input wire drive_in_t                 drive_in,
  input wire logic [`ADDR_W-1:0]        reg_addr,
  input wire logic [`DATA_W-1:0]        reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [`DATA_W-1:0]        reg_rdata,
  input wire logic [`NUM_TERMINALS-1:0] terminal_out,
  input wire flags_t                    flags
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // The tick runs free, so the first tick of a hold may be short
  localparam int unsigned HOLD_MIN = (`REGEN_HOLD_MS - 1) * TICK_CYCLES - 1;
  logic [31:0] regen_age;
  logic        open_loop;
  assign open_loop = drive_in.method inside {CM_VF, CM_AMFV, CM_SLV};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      regen_age <= '0;
    end else begin
      regen_age <= flags.regen_state_flag ? regen_age + 32'h0000_0001 : '0;
    end
  end
  sequence s_trip_then_reset;
    drive_in.trip ##1 drive_in.reset_period;
  endsequence
  AST_DIR_SIGN: assert property (
    drive_in.method == CM_VECTOR && drive_in.running &&
    !drive_in.pre_excitation && drive_in.motor_speed > 0
    |=> flags[1:0] == 2'b01) else $error("forward flag wrong");
  AST_DIR_PREEXC: assert property (
    drive_in.pre_excitation && drive_in.mode != MODE_POSITION
    |=> flags[1:0] == 2'b00) else $error("direction set in pre-excitation");
  AST_OPEN_LOOP: assert property (
    open_loop |=> flags[2:0] == 3'b000) else $error("flag set open loop");
  AST_DIR_STOP: assert property (
    !drive_in.running |=> flags[1:0] == 2'b00)
    else $error("direction set while stopped");
  AST_REGEN_HOLD: assert property (
    $fell(flags.regen_state_flag) && $past(drive_in.running) &&
    !$past(drive_in.pre_excitation) && !$past(open_loop)
    |-> regen_age >= HOLD_MIN) else $error("regen hold too short");
  AST_REGEN_OFF: assert property (
    !drive_in.running || drive_in.pre_excitation
    |=> !flags.regen_state_flag) else $error("regen set while stopped");
  AST_TRIP: assert property (
    drive_in.trip |=> flags.fault_out_primary && flags.fault_out_secondary)
    else $error("fault outputs missing on trip");
  AST_SEC_HOLD: assert property (
    s_trip_then_reset |=> flags.fault_out_secondary)
    else $error("secondary fault dropped in reset period");
  AST_SHUTOFF: assert property (
    drive_in.trip && drive_in.fault_code inside {[`FC_INRUSH:`FC_BRAKE_TR]}
    |=> flags.supply_contactor_shutoff) else $error("shutoff missing");
  AST_FREQ_OFF: assert property (
    drive_in.dc_brake || drive_in.pre_excitation || drive_in.start_tuning
    |=> flags[13:6] == 8'h00) else $error("frequency flag set when held");
endmodule // drive_status_checker

bind drive_status_signal_generator drive_status_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) u_checker (
  .clk_sys(clk_sys), .rst(rst), .drive_in(drive_in), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .terminal_out(terminal_out), .flags(flags)
);

// >>> dv/drive_status_signal_generator_bench.sv
`timescale 1ns/10ps
`include "drive_status_params.svh"
module drive_status_signal_generator_bench import drive_status_pkg::*;;
  localparam int unsigned TICK = 10;
  logic                      clk_sys, rst, reg_wr, reg_rd;
  drive_in_t                 din;
  logic [`ADDR_W-1:0]        reg_addr;
  logic [`DATA_W-1:0]        reg_wdata, reg_rdata, rd_val;
  logic [`NUM_TERMINALS-1:0] terminal_out, seen;
  flags_t                    flags;
  int                        fail_count, n_checks;
  drive_status_signal_generator #(.TICK_CYCLES(TICK)) dut (
    .clk_sys(clk_sys), .rst(rst), .drive_in(din), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .terminal_out(terminal_out), .flags(flags));
  terminal_reader u_reader (.clk_sys(clk_sys), .rst(rst),
    .terminal_out(terminal_out), .seen(seen));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic dir_case(input logic run, input logic pre,
      input ctrl_mode_t md, input ctrl_method_t cm,
      input logic signed [`SPEED_W-1:0] spd, input logic [1:0] ex);
    @(posedge clk_sys);
    din.running <= run;
    din.pre_excitation <= pre;
    din.mode <= md;
    din.method <= cm;
    din.motor_speed <= spd;
    settle(3);
    chk(16'(flags[1:0]), 16'(ex));
  endtask
  task automatic freq_case(input ctrl_method_t cm,
      input logic signed [`SPEED_W-1:0] fo, input logic signed [`SPEED_W-1:0] fc,
      input logic signed [`SPEED_W-1:0] ms, input logic [7:0] ex);
    @(posedge clk_sys);
    din.running <= 1'b1;
    din.method <= cm;
    din.output_freq <= fo;
    din.freq_command <= fc;
    din.motor_speed <= ms;
    settle(3);
    chk(16'(flags[13:6]), 16'(ex));
  endtask
  task automatic fault_case(input logic [7:0] code, input logic [2:0] ex);
    @(posedge clk_sys);
    din.trip <= 1'b1;
    din.fault_code <= code;
    settle(3);
    chk(16'(flags[5:3]), 16'(ex));
    @(posedge clk_sys);
    din.trip <= 1'b0;
    settle(2);
  endtask
  task automatic t_regs;
    logic [15:0] dflt [7] = '{16'h000A, 16'h0258, 16'h270F, 16'h0BB8,
                              16'h1770, 16'h0096, 16'h0096};
    for (int i = 0; i < 7; i++) begin
      rd(8'(4 * i));
      chk(rd_val, dflt[i]);
    end
    rd(8'hFC);
    chk(rd_val, 16'h0000);
    rd(`REG_TERM_BASE);
    chk(rd_val, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_dir;
    wr(`REG_TERM_BASE, 16'h001E);
    wr(`REG_TERM_BASE + 8'h04, 16'h0083);
    dir_case(1'b1, 1'b0, MODE_SPEED, CM_VECTOR, 17'sd500, 2'b01);
    chk(16'(seen[1:0]), 16'h0003);
    dir_case(1'b1, 1'b0, MODE_SPEED, CM_VECTOR, -17'sd500, 2'b10);
    chk(16'(seen[1:0]), 16'h0000);
    dir_case(1'b1, 1'b1, MODE_SPEED, CM_VECTOR, 17'sd500, 2'b00);
    dir_case(1'b1, 1'b1, MODE_TORQUE, CM_VECTOR, -17'sd500, 2'b00);
    dir_case(1'b1, 1'b1, MODE_POSITION, CM_VECTOR, -17'sd500, 2'b10);
    dir_case(1'b0, 1'b0, MODE_SPEED, CM_VECTOR, 17'sd500, 2'b00);
    dir_case(1'b1, 1'b0, MODE_SPEED, CM_SLV, 17'sd500, 2'b00);
    dir_case(1'b1, 1'b0, MODE_SPEED, CM_AMFV, 17'sd500, 2'b00);
    dir_case(1'b1, 1'b0, MODE_SPEED, CM_VF, 17'sd500, 2'b00);
    $display("t_dir done");
  endtask
  task automatic t_regen;
    wr(`REG_TERM_BASE + 8'h08, 16'h0020);
    wr(`REG_TERM_BASE + 8'h0C, 16'h0084);
    dir_case(1'b1, 1'b0, MODE_SPEED, CM_VECTOR, 17'sd500, 2'b01);
    @(posedge clk_sys);
    din.regenerating <= 1'b1;
    @(posedge clk_sys);
    din.regenerating <= 1'b0;
    settle(3);
    chk(16'(seen[3:2]), 16'h0001);
    settle(80 * TICK);
    chk(16'(flags.regen_state_flag), 16'h0001);
    settle(30 * TICK);
    chk(16'(flags.regen_state_flag), 16'h0000);
    @(posedge clk_sys);
    din.regenerating <= 1'b1;
    din.pre_excitation <= 1'b1;
    settle(3);
    chk(16'(flags.regen_state_flag), 16'h0000);
    @(posedge clk_sys);
    din.pre_excitation <= 1'b0;
    din.running <= 1'b0;
    settle(3);
    chk(16'(flags.regen_state_flag), 16'h0000);
    @(posedge clk_sys);
    din.regenerating <= 1'b0;
    $display("t_regen done");
  endtask
  task automatic t_fault;
    wr(`REG_TERM_BASE + 8'h10, 16'h005E);
    wr(`REG_TERM_BASE + 8'h14, 16'h00BF);
    for (int c = 1; c <= 12; c++) begin
      fault_case(8'(c), 3'b111);
    end
    fault_case(8'h20, 3'b011);
    @(posedge clk_sys);
    din.trip <= 1'b1;
    din.fault_code <= `FC_PHASE_LOSS;
    settle(3);
    chk(16'(seen[5:4]), 16'h0001);
    @(posedge clk_sys);
    din.trip <= 1'b0;
    din.reset_period <= 1'b1;
    settle(3);
    chk(16'(flags[5:3]), 16'h0002);
    @(posedge clk_sys);
    din.reset_period <= 1'b0;
    settle(3);
    chk(16'(flags[5:3]), 16'h0000);
    $display("t_fault done");
  endtask
  task automatic t_freq;
    int fv [11] = '{599, 600, 149, 150, 1100, 1101, 2999, 3000, 5999,
                    6000, -600};
    logic [7:0] fx [11] = '{8'h00, 8'h06, 8'h80, 8'h00, 8'h07, 8'h06,
                            8'h06, 8'h1E, 8'h1E, 8'h7E, 8'h06};
    logic [7:0] cd [7] = '{8'h04, 8'h69, 8'h06, 8'h29, 8'h2A, 8'h8F, 8'h22};
    @(posedge clk_sys);
    din.set_freq <= 16'h03E8;
    for (int i = 0; i < 11; i++) begin
      freq_case(CM_VF, 17'(fv[i]), 17'sd0, 17'sd0, fx[i]);
    end
    for (int i = 0; i < 7; i++) begin
      wr(`REG_TERM_BASE + 8'(4 * i), {8'h00, cd[i]});
    end
    freq_case(CM_VF, 17'sd3000, 17'sd0, 17'sd0, 8'h1E);
    chk(16'(seen), 16'h0039);
    freq_case(CM_VECTOR, 17'sd0, 17'sd3000, 17'sd700, 8'h0E);
    freq_case(CM_ENC_FB, 17'sd0, 17'sd0, 17'sd3000, 8'h1E);
    wr(`REG_REV_THRESH, 16'h03E8);
    rd(`REG_REV_THRESH);
    chk(rd_val, 16'h03E8);
    freq_case(CM_VF, -17'sd800, 17'sd0, 17'sd0, 8'h00);
    freq_case(CM_VF, -17'sd1000, 17'sd0, 17'sd0, 8'h07);
    freq_case(CM_VF, 17'sd800, 17'sd0, 17'sd0, 8'h06);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      {din.dc_brake, din.pre_excitation, din.start_tuning} <= 3'b100 >> k;
      freq_case(CM_VF, 17'sd6000, 17'sd0, 17'sd0, 8'h00);
      @(posedge clk_sys);
      {din.dc_brake, din.pre_excitation, din.start_tuning} <= 3'b000;
    end
    $display("t_freq done");
  endtask
  task automatic t_stall;
    @(posedge clk_sys);
    din.method <= CM_VECTOR;
    din.running <= 1'b1;
    din.motor_speed <= 17'sd100;
    din.torque <= 16'h00C8;
    din.torque_limit_active <= 1'b1;
    settle(2990 * TICK);
    chk(16'(flags.stall_trip_fault), 16'h0000);
    settle(20 * TICK);
    chk(16'(flags.stall_trip_fault), 16'h0001);
    @(posedge clk_sys);
    din.torque_limit_active <= 1'b0;
    settle(3);
    rd(`REG_STATUS);
    chk(rd_val, 16'h6001);
    @(posedge clk_sys);
    din.fault_reset <= 1'b1;
    settle(3);
    chk(16'(flags.stall_trip_fault), 16'h0000);
    $display("t_stall done");
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    din = '0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    fail_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs;
    t_dir;
    t_regen;
    t_fault;
    t_freq;
    t_stall;
    report_and_stop;
  end
  // About 32000 cycles are needed, mostly the stall wait; a hang is cut later
  initial begin
    #(50000 * 10);
    fail_count++;
    report_and_stop;
  end
endmodule // drive_status_signal_generator_bench
